// File: bench/fdrs_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) chk(nm, e, g)
module fdrs_core_tb;
	logic                  clk, sys_rst, reset_pin_in, dor_wr, dor_reset_bit, dsr_wr;
	logic                  dsr_reset_bit, specify_wr, configure_wr, poll_disable, powerdown_req;
	logic                  cmd_start, cmd_done, cmd_invalid, poll_abort, terminal_count_in;
	logic                  id_valid, result_rd, index_in, trk_load, motor_on, wp_set;
	logic [7:0]            specify_data, id_track, cur_track, trk_val;
	fdrs_pkg::fdrs_cmd_t   cmd_kind;
	fdrs_pkg::fdrs_evt_t   evt, e;
	fdrs_pkg::fdrs_pins_t  pins;
	logic                  core_reset, dor_reset_active, power_down, polling_en, abort_pulse;
	logic                  cmd_active, result_ready;
	logic [7:0]            specify_value, result_byte, drive_pin_status;
	int                    err_total, cmp_count;
	localparam logic       HD = 1'b1;
	localparam logic [1:0] DS = 2'h2;

	fdrs_core i_dut (
		.clk, .sys_rst, .reset_pin_in, .dor_wr, .dor_reset_bit, .dsr_wr, .dsr_reset_bit,
		.specify_wr, .specify_data, .configure_wr, .poll_disable, .powerdown_req, .cmd_start,
		.cmd_kind, .cmd_done, .cmd_invalid, .poll_abort, .evt, .index_in, .terminal_count_in,
		.id_valid, .id_track, .cur_track, .pins, .result_rd, .core_reset, .dor_reset_active,
		.power_down, .polling_en, .abort_pulse, .specify_value, .cmd_active, .result_ready,
		.result_byte, .drive_pin_status
	);

	fdrs_drive_model i_drive (
		.clk, .step_pulse(evt.step_pulse), .step_outward(evt.step_outward), .load(trk_load),
		.load_trk(trk_val), .motor_on, .wp_set, .head_set(HD), .ds_set(DS), .pins, .index_in
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
		cmp_count++;
		if (g !== ex)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic leave_reset();
		dor_wr = 1'b1;
		dor_reset_bit = 1'b0;
		cyc(1);
		dor_wr = 1'b0;
		cyc(3);
	endtask : leave_reset

	task automatic dsr_pulse();
		dsr_wr = 1'b1;
		dsr_reset_bit = 1'b1;
		cyc(1);
		dsr_wr = 1'b0;
	endtask : dsr_pulse

	task automatic fire(input fdrs_pkg::fdrs_evt_t ev);
		evt = ev;
		cyc(1);
		evt = '0;
		cyc(1);
	endtask : fire

	task automatic start_cmd(input fdrs_pkg::fdrs_cmd_t k, input logic [7:0] t);
		trk_val = t;
		trk_load = 1'b1;
		cyc(1);
		trk_load = 1'b0;
		cyc(1);
		cmd_kind = k;
		cmd_start = 1'b1;
		cyc(1);
		cmd_start = 1'b0;
		e = '0;
	endtask : start_cmd

	task automatic read_byte(input logic [7:0] ex);
		int n;
		n = 0;
		while (result_ready !== 1'b1 && n < 20)
		begin
			cyc(1);
			n++;
		end
		if (n == 20)
		begin
			err_total++;
			$display("CHECK FAILED result_ready expected 1 seen %b", result_ready);
			test_done();
		end
		`CHK("result_byte", ex, result_byte);
		result_rd = 1'b1;
		cyc(1);
		result_rd = 1'b0;
	endtask : read_byte

	// how: 0 done, 1 invalid, 2 polling abort
	task automatic end_cmd(input int how, input logic [7:0] e0, e1, e2, input logic t0);
		logic [7:0] exp_b [4];
		exp_b = '{e0 | {5'h00, HD, DS}, e1, e2, {1'b0, wp_set, 1'b1, t0, 1'b1, HD, DS}};
		cmd_done = how == 0;
		cmd_invalid = how == 1;
		poll_abort = how == 2;
		cyc(1);
		{cmd_done, cmd_invalid, poll_abort} = 3'h0;
		for (int i = 0; i < 4; i++)
			read_byte(exp_b[i]);
		$display("test command %0d finished", cmd_kind);
	endtask : end_cmd

	initial
	begin
		{reset_pin_in, dor_wr, dor_reset_bit, dsr_wr, dsr_reset_bit, specify_wr} = '0;
		{configure_wr, poll_disable, powerdown_req, cmd_start, cmd_done, cmd_invalid} = '0;
		{poll_abort, terminal_count_in, id_valid, result_rd, motor_on, wp_set} = '0;
		{specify_data, id_track, cur_track} = '0;
		trk_val = 8'h00;
		trk_load = 1'b1;
		cmd_kind = fdrs_pkg::CK_OTHER;
		evt = '0;
		e = '0;
		err_total = 0;
		cmp_count = 0;
		sys_rst = 1'b1;
		cyc(10);
		sys_rst = 1'b0;
		cyc(2);
		`CHK("core_reset", 8'h01, {7'h00, core_reset});
		`CHK("dor_reset_active", 8'h01, {7'h00, dor_reset_active});
		leave_reset();
		`CHK("polling_en", 8'h01, {7'h00, polling_en});
		$display("test power-on reset finished");

		specify_data = 8'h5a;
		specify_wr = 1'b1;
		cyc(1);
		specify_wr = 1'b0;
		reset_pin_in = 1'b1;
		cyc(1);
		reset_pin_in = 1'b0;
		cyc(2);
		`CHK("dor_reset_active", 8'h01, {7'h00, dor_reset_active});
		`CHK("core_reset", 8'h01, {7'h00, core_reset});
		`CHK("specify_value", 8'h5a, specify_value);
		leave_reset();
		`CHK("core_reset", 8'h00, {7'h00, core_reset});
		$display("test pin reset finished");

		poll_disable = 1'b1;
		configure_wr = 1'b1;
		cyc(1);
		configure_wr = 1'b0;
		powerdown_req = 1'b1;
		cyc(1);
		powerdown_req = 1'b0;
		cyc(2);
		`CHK("polling_en", 8'h00, {7'h00, polling_en});
		`CHK("power_down", 8'h01, {7'h00, power_down});
		dsr_pulse();
		`CHK("core_reset", 8'h01, {7'h00, core_reset});
		cyc(3);
		`CHK("core_reset", 8'h00, {7'h00, core_reset});
		`CHK("power_down", 8'h00, {7'h00, power_down});
		`CHK("polling_en", 8'h01, {7'h00, polling_en});
		$display("test rate reset finished");

		start_cmd(fdrs_pkg::CK_WRITE_DATA, 8'h00);
		dsr_pulse();
		cyc(1);
		`CHK("abort_pulse", 8'h01, {7'h00, abort_pulse});
		cyc(3);
		`CHK("cmd_active", 8'h00, {7'h00, cmd_active});
		`CHK("result_ready", 8'h00, {7'h00, result_ready});
		$display("test abort finished");

		start_cmd(fdrs_pkg::CK_SEEK, 8'h00);
		end_cmd(0, 8'h20, 8'h00, 8'h00, 1'b1);
		start_cmd(fdrs_pkg::CK_RECAL, 8'h64);
		e.step_pulse = 1'b1;
		e.step_outward = 1'b1;
		repeat (80) fire(e);
		end_cmd(0, 8'h70, 8'h00, 8'h00, 1'b0);
		start_cmd(fdrs_pkg::CK_REL_SEEK, 8'h01);
		e.step_pulse = 1'b1;
		e.step_outward = 1'b1;
		repeat (2) fire(e);
		end_cmd(0, 8'h70, 8'h00, 8'h00, 1'b1);
		start_cmd(fdrs_pkg::CK_READ_DATA, 8'h00);
		e.crc_id_err = 1'b1;
		e.crc_data_err = 1'b1;
		e.svc_late = 1'b1;
		e.deleted_mark = 1'b1;
		fire(e);
		end_cmd(0, 8'h40, 8'hb0, 8'h60, 1'b1);

		start_cmd(fdrs_pkg::CK_READ_DATA, 8'h00);
		{cur_track, id_track, id_valid, terminal_count_in} = {8'h05, 8'hff, 2'h3};
		e.sector_not_found = 1'b1;
		fire(e);
		{id_valid, terminal_count_in} = 2'h0;
		end_cmd(0, 8'h40, 8'h04, 8'h12, 1'b1);
		start_cmd(fdrs_pkg::CK_WRITE_DATA, 8'h00);
		{wp_set, id_track, id_valid, terminal_count_in} = {1'b1, 8'h07, 2'h3};
		fire(e);
		{id_valid, terminal_count_in} = 2'h0;
		`CHK("drive_pin_status", {2'h1, 3'h7, HD, DS}, drive_pin_status);
		end_cmd(0, 8'h40, 8'h02, 8'h10, 1'b1);
		wp_set = 1'b0;

		start_cmd(fdrs_pkg::CK_READ_ID, 8'h00);
		motor_on = 1'b1;
		cyc(45);
		motor_on = 1'b0;
		end_cmd(0, 8'h40, 8'h01, 8'h00, 1'b1);
		start_cmd(fdrs_pkg::CK_READ_DEL, 8'h00);
		terminal_count_in = 1'b1;
		e.data_mark = 1'b1;
		fire(e);
		terminal_count_in = 1'b0;
		e = '0;
		e.no_data_mark = 1'b1;
		fire(e);
		end_cmd(0, 8'h40, 8'h01, 8'h41, 1'b1);
		for (int i = 0; i < 2; i++)
		begin
			start_cmd(i ? fdrs_pkg::CK_READ_TRACK : fdrs_pkg::CK_READ_ID, 8'h00);
			e.id_read_fail = i == 0;
			e.seq_err = i == 1;
			terminal_count_in = 1'b1;
			fire(e);
			terminal_count_in = 1'b0;
			end_cmd(0, 8'h40, 8'h04, 8'h00, 1'b1);
		end
		for (int i = 1; i < 3; i++)
		begin
			// invalid arrives from idle, polling abort from execution
			if (i == 2)
				start_cmd(fdrs_pkg::CK_OTHER, 8'h00);
			end_cmd(i, (i == 1) ? 8'h80 : 8'hc0, 8'h00, 8'h00, 1'b1);
		end
		test_done();
	end
endmodule : fdrs_core_tb
`default_nettype wire

// File: bench/fdrs_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
// floppy drive seen from the cable: head position, index, write protect
module fdrs_drive_model #(
	parameter int IDX_GAP = 20
) (
	input  wire logic            clk,
	input  wire logic            step_pulse,
	input  wire logic            step_outward,
	input  wire logic            load,
	input  wire logic [7:0]      load_trk,
	input  wire logic            motor_on,
	input  wire logic            wp_set,
	input  wire logic            head_set,
	input  wire logic [1:0]      ds_set,
	output var fdrs_pkg::fdrs_pins_t pins,
	output logic                 index_in
);
	logic [7:0] trk_q;
	int         rot_q = 0;

	// the head stops mechanically at track zero
	always_ff @(posedge clk)
	begin
		if (load)
			trk_q <= load_trk;
		else if (step_pulse && step_outward && trk_q != 8'h00)
			trk_q <= trk_q - 8'h01;
		else if (step_pulse && !step_outward)
			trk_q <= trk_q + 8'h01;
		rot_q <= (motor_on && rot_q < IDX_GAP - 1) ? rot_q + 1 : 0;
	end

	// no index while the spindle stands
	assign index_in = motor_on && rot_q == IDX_GAP - 1;
	assign pins = '{wp_in: wp_set, track_zero_in: trk_q == 8'h00,
		head_select_out: head_set, drive_sel: ds_set};
endmodule : fdrs_drive_model
`default_nettype wire

// File: design/fdrs_cfg.svh
`ifndef FDRS_CFG_SVH
`define FDRS_CFG_SVH
// termination codes
`define FDRS_IC_NORMAL    2'h0
`define FDRS_IC_ABNORMAL  2'h1
`define FDRS_IC_INVALID   2'h2
`define FDRS_IC_POLLED    2'h3
// first status byte fields
`define FDRS_S0_IC_HI     7
`define FDRS_S0_IC_LO     6
`define FDRS_S0_SEEK      5
`define FDRS_S0_EQUIP     4
`define FDRS_S0_ZERO      3
`define FDRS_S0_HEAD      2
// second status byte fields
`define FDRS_S1_EOC       7
`define FDRS_S1_CRC       5
`define FDRS_S1_LATE      4
`define FDRS_S1_NODATA    2
`define FDRS_S1_WPROT     1
`define FDRS_S1_NOMARK    0
// third status byte fields
`define FDRS_S2_CMARK     6
`define FDRS_S2_CRCPAY    5
`define FDRS_S2_WCYL      4
`define FDRS_S2_BCYL      1
`define FDRS_S2_NOPAY     0
// drive pin status byte fields
`define FDRS_S3_WP        6
`define FDRS_S3_ONE_HI    5
`define FDRS_S3_T0        4
`define FDRS_S3_ONE_LO    3
`define FDRS_S3_HEAD      2
// counts and codes
`define FDRS_RECAL_STEPS  7'h50
`define FDRS_INDEX_LIMIT  2'h2
`define FDRS_BAD_TRACK    8'hff
`define FDRS_RESULT_LAST  2'h3
// reset values
`define FDRS_DOR_RST_INIT 1'h1
`define FDRS_DSR_RST_INIT 1'h0
`define FDRS_SPECIFY_INIT 8'h00
`define FDRS_POLLDIS_INIT 1'h0
`endif

// File: design/fdrs_core.sv
// Notes on behaviour
// R1: first byte bits 7:6 give termination: 00 ok, 01 abnormal, 10 invalid, 11 polling.
// R2: first byte bit 5 set when seek, relative seek or recalibrate completes.
// R3: bit 4 set if track zero absent after 80 recal steps or relative seek steps outward at zero.
// R4: first byte carries head in bit 2, drive in bits 1:0, bit 3 zero.
// R5: second byte bit 7 on access past last sector or data command without terminal count.
// R6: second byte bit 5 on any ID or data CRC error; bits 6 and 3 zero.
// R7: second byte bit 4 when host or DMA service comes too late.
// R8: second byte bit 2 on missing sector, failed ID read or bad track sequence.
// R9: second byte bit 1 when write protect active during write or format.
// R10: second byte bit 0 on no ID mark after two index pulses, or no data mark.
// R11: third byte bit 6 when read meets the opposite kind of data mark.
// R12: third byte bit 5 on data field CRC error; bits 7, 3, 2 zero.
// R13: third byte bit 4 when ID track differs from internal track.
// R14: third byte bit 1 when ID track differs and equals ff.
// R15: third byte bit 0 when no data or deleted data mark is found.
// R16: fourth byte shows live pins; bits 5 and 3 one, bit 7 zero.
// R17: reset from pin, output register bit, rate register bit and power-on.
// R18: any reset source ends power-down.
// R19: reset aborts the running operation and goes idle.
// R20: leaving reset clears registers and configure settings, then awaits a command.
// R21: polling starts after reset unless configure disables it.
// R22: rate reset self-clears; output reset held by host, wins, set by pin reset.
// R23: pin reset clears everything except the specify timing values.
// R24: status bytes captured at command end and held until read out.
`timescale 1ns/1ns
`default_nettype none
`include "fdrs_cfg.svh"
module fdrs_core (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                reset_pin_in,
	input  wire logic                dor_wr,
	input  wire logic                dor_reset_bit,
	input  wire logic                dsr_wr,
	input  wire logic                dsr_reset_bit,
	input  wire logic                specify_wr,
	input  wire logic [7:0]          specify_data,
	input  wire logic                configure_wr,
	input  wire logic                poll_disable,
	input  wire logic                powerdown_req,
	input  wire logic                cmd_start,
	input  wire fdrs_pkg::fdrs_cmd_t  cmd_kind,
	input  wire logic                cmd_done,
	input  wire logic                cmd_invalid,
	input  wire logic                poll_abort,
	input  wire fdrs_pkg::fdrs_evt_t  evt,
	input  wire logic                index_in,
	input  wire logic                terminal_count_in,
	input  wire logic                id_valid,
	input  wire logic [7:0]          id_track,
	input  wire logic [7:0]          cur_track,
	input  wire fdrs_pkg::fdrs_pins_t pins,
	input  wire logic                result_rd,
	output logic                     core_reset,
	output logic                     dor_reset_active,
	output logic                     power_down,
	output logic                     polling_en,
	output logic                     abort_pulse,
	output logic [7:0]               specify_value,
	output logic                     cmd_active,
	output logic                     result_ready,
	output logic [7:0]               result_byte,
	output logic [7:0]               drive_pin_status
);
	function automatic logic is_write(input fdrs_pkg::fdrs_cmd_t k);
		is_write = (k == fdrs_pkg::CK_WRITE_DATA) || (k == fdrs_pkg::CK_WRITE_DEL)
			|| (k == fdrs_pkg::CK_FORMAT);
	endfunction : is_write

	function automatic logic is_data_xfer(input fdrs_pkg::fdrs_cmd_t k);
		is_data_xfer = (k == fdrs_pkg::CK_READ_DATA) || (k == fdrs_pkg::CK_READ_DEL)
			|| (k == fdrs_pkg::CK_WRITE_DATA) || (k == fdrs_pkg::CK_WRITE_DEL);
	endfunction : is_data_xfer

	function automatic logic [7:0] pin_byte(input fdrs_pkg::fdrs_pins_t p);
		pin_byte = 8'h00;
		pin_byte[`FDRS_S3_WP]     = p.wp_in;
		pin_byte[`FDRS_S3_ONE_HI] = 1'b1;
		pin_byte[`FDRS_S3_T0]     = p.track_zero_in;
		pin_byte[`FDRS_S3_ONE_LO] = 1'b1;
		pin_byte[`FDRS_S3_HEAD]   = p.head_select_out;
		pin_byte[1:0]             = p.drive_sel;
	endfunction : pin_byte

	// reset control group
	logic       dor_rst_q, dor_rst_d;
	logic       dsr_rst_q, dsr_rst_d;
	logic [7:0] specify_q, specify_d;
	logic       poll_dis_q, poll_dis_d;
	logic       pd_q, pd_d;
	logic       hard_rst;

	assign hard_rst   = sys_rst | reset_pin_in;
	assign core_reset = hard_rst | dor_rst_q | dsr_rst_q; // R17

	always_comb
	begin
		dor_rst_d = dor_rst_q;
		if (hard_rst)
			dor_rst_d = 1'b1; // R22
		else if (dor_wr)
			dor_rst_d = dor_reset_bit;
		dsr_rst_d = dsr_wr & dsr_reset_bit & ~hard_rst; // R22
		specify_d = specify_wr ? specify_data : specify_q; // R23
		poll_dis_d = poll_dis_q;
		if (core_reset)
			poll_dis_d = `FDRS_POLLDIS_INIT; // R20
		else if (configure_wr)
			poll_dis_d = poll_disable;
		pd_d = pd_q;
		if (core_reset)
			pd_d = 1'b0; // R18
		else if (powerdown_req)
			pd_d = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			dor_rst_q  <= `FDRS_DOR_RST_INIT;
			dsr_rst_q  <= `FDRS_DSR_RST_INIT;
			specify_q  <= `FDRS_SPECIFY_INIT;
			poll_dis_q <= `FDRS_POLLDIS_INIT;
			pd_q       <= 1'b0;
		end
		else
		begin
			dor_rst_q  <= dor_rst_d;
			dsr_rst_q  <= dsr_rst_d;
			specify_q  <= specify_d;
			poll_dis_q <= poll_dis_d;
			pd_q       <= pd_d;
		end
	end

	// sequencing group
	fdrs_pkg::fdrs_state_t state_q, state_d;
	fdrs_pkg::fdrs_cmd_t   kind_q, kind_d;
	logic [6:0]           step_cnt_q, step_cnt_d;
	logic [1:0]           idx_cnt_q, idx_cnt_d;
	logic                 tc_seen_q, tc_seen_d;
	logic [1:0]           rd_idx_q, rd_idx_d;
	logic                 lag_q, lag_d;
	logic                 abort_q, abort_d;
	logic                 in_exec, finish, capture, rd_take;

	assign in_exec = (state_q == fdrs_pkg::ST_EXEC);
	assign finish  = cmd_invalid | poll_abort | (in_exec & cmd_done);
	assign capture = ~core_reset & finish
		& ((state_q == fdrs_pkg::ST_IDLE) | in_exec); // R24
	assign rd_take = result_rd & result_ready;

	always_comb
	begin
		state_d    = state_q;
		kind_d     = kind_q;
		step_cnt_d = step_cnt_q;
		idx_cnt_d  = idx_cnt_q;
		tc_seen_d  = tc_seen_q;
		rd_idx_d   = rd_idx_q;
		lag_d      = capture | rd_take;
		abort_d    = core_reset & in_exec; // R19
		if (core_reset)
			state_d = fdrs_pkg::ST_RST; // R19
		else
		begin
			case (state_q)
				fdrs_pkg::ST_RST:
					state_d = fdrs_pkg::ST_IDLE; // R20
				fdrs_pkg::ST_IDLE:
					if (capture)
						state_d = fdrs_pkg::ST_RES;
					else if (cmd_start)
					begin
						state_d    = fdrs_pkg::ST_EXEC;
						kind_d     = cmd_kind;
						step_cnt_d = 7'h00;
						idx_cnt_d  = 2'h0;
						tc_seen_d  = 1'b0;
					end
				fdrs_pkg::ST_EXEC:
				begin
					if (evt.step_pulse && step_cnt_q != `FDRS_RECAL_STEPS)
						step_cnt_d = step_cnt_q + 7'h01;
					if (evt.id_mark_found)
						idx_cnt_d = 2'h0;
					else if (index_in && idx_cnt_q != `FDRS_INDEX_LIMIT)
						idx_cnt_d = idx_cnt_q + 2'h1;
					if (terminal_count_in)
						tc_seen_d = 1'b1;
					if (capture)
						state_d = fdrs_pkg::ST_RES;
				end
				fdrs_pkg::ST_RES:
					if (rd_take)
					begin
						if (rd_idx_q == `FDRS_RESULT_LAST)
							state_d = fdrs_pkg::ST_IDLE;
						rd_idx_d = rd_idx_q + 2'h1;
					end
				default:
					state_d = fdrs_pkg::ST_RST;
			endcase
		end
		if (capture || core_reset)
			rd_idx_d = 2'h0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q    <= fdrs_pkg::ST_RST;
			kind_q     <= fdrs_pkg::CK_OTHER;
			step_cnt_q <= 7'h00;
			idx_cnt_q  <= 2'h0;
			tc_seen_q  <= 1'b0;
			rd_idx_q   <= 2'h0;
			lag_q      <= 1'b0;
			abort_q    <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			kind_q     <= kind_d;
			step_cnt_q <= step_cnt_d;
			idx_cnt_q  <= idx_cnt_d;
			tc_seen_q  <= tc_seen_d;
			rd_idx_q   <= rd_idx_d;
			lag_q      <= lag_d;
			abort_q    <= abort_d;
		end
	end

	// error flag group; a set in the idle clearing cycle survives, core_reset drops it
	fdrs_pkg::fdrs_flags_t flags_q, flags_d, set_f;
	logic                  cyl_diff, any_err, rd_kind;
	fdrs_pkg::fdrs_result_t cap_res;
	logic [1:0]            ic;

	assign cyl_diff = id_valid & (id_track != cur_track);
	assign rd_kind  = (kind_q == fdrs_pkg::CK_READ_DATA) | (kind_q == fdrs_pkg::CK_READ_DEL);

	always_comb
	begin
		set_f = '0;
		if (in_exec)
		begin
			set_f.seek_finished = cmd_done & ((kind_q == fdrs_pkg::CK_SEEK)
				| (kind_q == fdrs_pkg::CK_REL_SEEK) | (kind_q == fdrs_pkg::CK_RECAL)); // R2
			set_f.equipment_fault = ((kind_q == fdrs_pkg::CK_RECAL)
				& (step_cnt_q == `FDRS_RECAL_STEPS) & ~pins.track_zero_in)
				| ((kind_q == fdrs_pkg::CK_REL_SEEK) & evt.step_pulse
				& evt.step_outward & pins.track_zero_in); // R3
			set_f.end_of_cyl = evt.sector_beyond_eot
				| (cmd_done & is_data_xfer(kind_q) & ~tc_seen_q & ~terminal_count_in); // R5
			set_f.crc_fault_any = evt.crc_id_err | evt.crc_data_err; // R6
			set_f.svc_late = evt.svc_late; // R7
			set_f.sector_missing = (rd_kind & evt.sector_not_found)
				| ((kind_q == fdrs_pkg::CK_READ_ID) & evt.id_read_fail)
				| ((kind_q == fdrs_pkg::CK_READ_TRACK) & evt.seq_err); // R8
			set_f.write_blocked = is_write(kind_q) & pins.wp_in; // R9
			set_f.mark_missing = (idx_cnt_q == `FDRS_INDEX_LIMIT)
				| evt.no_data_mark; // R10
			set_f.ctrl_mark = ((kind_q == fdrs_pkg::CK_READ_DATA) & evt.deleted_mark)
				| ((kind_q == fdrs_pkg::CK_READ_DEL) & evt.data_mark); // R11
			set_f.crc_fault_payload = evt.crc_data_err; // R12
			set_f.cylinder_mismatch = cyl_diff; // R13
			set_f.bad_track_flag = cyl_diff & (id_track == `FDRS_BAD_TRACK); // R14
			set_f.payload_mark_missing = evt.no_data_mark; // R15
		end
		flags_d = flags_q | set_f;
		if (core_reset)
			flags_d = '0;
		else if (state_q == fdrs_pkg::ST_IDLE && (cmd_start || finish))
			flags_d = set_f;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flags_q <= '0;
		else
			flags_q <= flags_d;
	end

	// result assembly at the finishing edge, same-cycle events included
	assign any_err = flags_d.equipment_fault | flags_d.end_of_cyl | flags_d.crc_fault_any
		| flags_d.svc_late | flags_d.sector_missing | flags_d.write_blocked
		| flags_d.mark_missing | flags_d.cylinder_mismatch;

	always_comb
	begin
		if (cmd_invalid)
			ic = `FDRS_IC_INVALID; // R1
		else if (poll_abort)
			ic = `FDRS_IC_POLLED;
		else if (any_err)
			ic = `FDRS_IC_ABNORMAL;
		else
			ic = `FDRS_IC_NORMAL;
		cap_res = '0;
		cap_res.s0[`FDRS_S0_IC_HI:`FDRS_S0_IC_LO] = ic; // R1
		cap_res.s0[`FDRS_S0_SEEK]  = flags_d.seek_finished;
		cap_res.s0[`FDRS_S0_EQUIP] = flags_d.equipment_fault;
		cap_res.s0[`FDRS_S0_ZERO]  = 1'b0; // R4
		cap_res.s0[`FDRS_S0_HEAD]  = pins.head_select_out; // R4
		cap_res.s0[1:0]            = pins.drive_sel; // R4
		cap_res.s1[`FDRS_S1_EOC]    = flags_d.end_of_cyl;
		cap_res.s1[`FDRS_S1_CRC]    = flags_d.crc_fault_any; // R6
		cap_res.s1[`FDRS_S1_LATE]   = flags_d.svc_late;
		cap_res.s1[`FDRS_S1_NODATA] = flags_d.sector_missing;
		cap_res.s1[`FDRS_S1_WPROT]  = flags_d.write_blocked;
		cap_res.s1[`FDRS_S1_NOMARK] = flags_d.mark_missing;
		cap_res.s2[`FDRS_S2_CMARK]  = flags_d.ctrl_mark;
		cap_res.s2[`FDRS_S2_CRCPAY] = flags_d.crc_fault_payload; // R12
		cap_res.s2[`FDRS_S2_WCYL]   = flags_d.cylinder_mismatch;
		cap_res.s2[`FDRS_S2_BCYL]   = flags_d.bad_track_flag;
		cap_res.s2[`FDRS_S2_NOPAY]  = flags_d.payload_mark_missing;
		cap_res.s3 = pin_byte(pins); // R16
	end

	fdrs_res_mem u_res_mem (
		.clk       (clk),
		.wr_en     (capture),
		.wr_data   (cap_res),
		.rd_addr   (rd_idx_q),
		.rd_data_q (result_byte)
	);

	logic [7:0] pin_q;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pin_q <= 8'h28;
		else
			pin_q <= pin_byte(pins); // R16
	end

	assign dor_reset_active = dor_rst_q;
	assign power_down       = pd_q;
	assign polling_en       = ~poll_dis_q & (state_q == fdrs_pkg::ST_IDLE); // R21
	assign abort_pulse      = abort_q;
	assign specify_value    = specify_q;
	assign cmd_active       = in_exec;
	assign result_ready     = (state_q == fdrs_pkg::ST_RES) & ~lag_q; // R24
	assign drive_pin_status = pin_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_ic_invalid: assert property ((state_q == fdrs_pkg::ST_IDLE) && cmd_invalid // R1
		&& !core_reset |-> ##2 (result_ready && result_byte[7:6] == 2'h2))
		else $error("invalid code wrong");
	chk_seek_end: assert property (in_exec && cmd_done && !core_reset && !cmd_invalid // R2
		&& !poll_abort && kind_q == fdrs_pkg::CK_RECAL |-> ##2 result_byte[5])
		else $error("seek end missing");
	chk_recal_fault: assert property (in_exec && kind_q == fdrs_pkg::CK_RECAL // R3
		&& !core_reset && step_cnt_q == 7'h50 && !pins.track_zero_in |=> flags_q.equipment_fault)
		else $error("equipment fault missing");
	chk_first_zero: assert property (result_ready && rd_idx_q == 2'h0 |-> !result_byte[3]) // R4
		else $error("first byte bit 3 set");
	chk_pin_fixed: assert property (result_ready && rd_idx_q == 2'h3 // R16
		|-> result_byte[5] && result_byte[3] && !result_byte[7])
		else $error("pin byte fixed bits wrong");
	chk_bad_track: assert property (in_exec && !core_reset && id_valid // R14
		&& id_track == 8'hff && cur_track != 8'hff
		|=> flags_q.bad_track_flag && flags_q.cylinder_mismatch)
		else $error("bad track not flagged");
	chk_dsr_clear: assert property (dsr_rst_q && !dsr_wr |=> !dsr_rst_q) // R22
		else $error("rate reset stuck");
	chk_pin_dor: assert property (reset_pin_in ##1 !dor_wr |-> dor_rst_q ##1 dor_rst_q) // R22
		else $error("pin reset did not arm output reset");
	chk_pd_exit: assert property (core_reset |=> !power_down) // R18
		else $error("power down survived reset");
	chk_reset_idle: assert property ($fell(core_reset) |-> state_q == fdrs_pkg::ST_RST // R20
		##1 (state_q == fdrs_pkg::ST_IDLE || $past(core_reset)))
		else $error("no idle after reset");
	chk_specify_keep: assert property (reset_pin_in && !specify_wr |=> $stable(specify_q)) // R23
		else $error("specify lost on pin reset");
	chk_result_hold: assert property (state_q == fdrs_pkg::ST_RES && !result_rd // R24
		&& !core_reset && !lag_q |=> $stable(result_byte)) else $error("result changed unread");

	cov_invalid: cover property (cmd_invalid && capture);
	cov_full_read: cover property (rd_take && rd_idx_q == 2'h3);
	cov_recal_fault: cover property (set_f.equipment_fault);
	cov_dor_release: cover property ($fell(dor_rst_q));
endmodule : fdrs_core
`default_nettype wire

// File: design/fdrs_pkg.sv
package fdrs_pkg;

	typedef enum logic [3:0] {
		CK_OTHER, CK_READ_DATA, CK_READ_DEL, CK_WRITE_DATA, CK_WRITE_DEL,
		CK_FORMAT, CK_READ_ID, CK_READ_TRACK, CK_SEEK, CK_REL_SEEK, CK_RECAL
	} fdrs_cmd_t;

	typedef enum logic [3:0] {
		ST_RST  = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_EXEC = 4'b0100,
		ST_RES  = 4'b1000
	} fdrs_state_t;

	typedef struct packed {
		logic crc_id_err;
		logic crc_data_err;
		logic svc_late;
		logic sector_not_found;
		logic id_read_fail;
		logic seq_err;
		logic deleted_mark;
		logic data_mark;
		logic id_mark_found;
		logic no_data_mark;
		logic sector_beyond_eot;
		logic step_pulse;
		logic step_outward;
	} fdrs_evt_t;

	typedef struct packed {
		logic       wp_in;
		logic       track_zero_in;
		logic       head_select_out;
		logic [1:0] drive_sel;
	} fdrs_pins_t;

	typedef struct packed {
		logic seek_finished;
		logic equipment_fault;
		logic end_of_cyl;
		logic crc_fault_any;
		logic svc_late;
		logic sector_missing;
		logic write_blocked;
		logic mark_missing;
		logic ctrl_mark;
		logic crc_fault_payload;
		logic cylinder_mismatch;
		logic bad_track_flag;
		logic payload_mark_missing;
	} fdrs_flags_t;

	typedef struct packed {
		logic [7:0] s0;
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
	} fdrs_result_t;

endpackage : fdrs_pkg

// File: design/fdrs_res_mem.sv
`timescale 1ns/1ns
`default_nettype none
// four result bytes, written together, read one at a time through a register
module fdrs_res_mem (
	input  wire logic                  clk,
	input  wire logic                  wr_en,
	input  wire fdrs_pkg::fdrs_result_t wr_data,
	input  wire logic [1:0]            rd_addr,
	output logic [7:0]                 rd_data_q
);
	logic [7:0] mem_q [0:3];
	logic [7:0] mem_d [0:3];
	logic [7:0] rd_data_d;

	always_comb
	begin
		mem_d[0] = mem_q[0];
		mem_d[1] = mem_q[1];
		mem_d[2] = mem_q[2];
		mem_d[3] = mem_q[3];
		if (wr_en)
		begin
			mem_d[0] = wr_data.s0;
			mem_d[1] = wr_data.s1;
			mem_d[2] = wr_data.s2;
			mem_d[3] = wr_data.s3;
		end
		rd_data_d = mem_q[rd_addr];
	end

	always_ff @(posedge clk)
	begin
		mem_q[0]  <= mem_d[0];
		mem_q[1]  <= mem_d[1];
		mem_q[2]  <= mem_d[2];
		mem_q[3]  <= mem_d[3];
		rd_data_q <= rd_data_d;
	end
endmodule : fdrs_res_mem
`default_nettype wire
